// ### hdl/fpdc_top.sv
// routine download controller: register file, sequencer, interrupt
`timescale 1ns/1ps
`default_nettype none
module fpdc_top #(
   parameter int ROUTINE_WORDS = 16,
   parameter int DATA_W = 32,
   parameter int ROM_AW = 12,
   parameter int RAM_AW = 16,
   parameter int BLK_SH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // cpu state: current code fetched from on-chip ram
   input wire logic exec_in_ram,
   // routine storage read port
   output logic [ROM_AW-1:0] rom_addr,
   input wire logic [DATA_W-1:0] rom_data,
   // on-chip ram write port
   output logic ram_we,
   output logic [RAM_AW-1:0] ram_addr,
   output logic [DATA_W-1:0] ram_wdata,
   // storage bank swap and interrupt
   output logic bank_switch,
   output logic irq
);
   localparam int COPY_LIM = ROUTINE_WORDS + 4;

   typedef struct packed {
      fpdc_pkg::fpdc_state_type st;
      logic req;
      logic psel;
      logic esel;
      logic emu;
      logic [7:0] key;
      logic [7:0] dest;
      logic [fpdc_pkg::EV_W-1:0] istat;
      logic [fpdc_pkg::EV_W-1:0] imask;
      logic start;
      logic erase_sel;
      logic dph_wr;
      logic [fpdc_pkg::OFS_W-1:0] dph_ofs;
      logic [31:0] rdata;
   } fpdc_top_state_type;

   localparam fpdc_top_state_type S_RST = '{
      st: fpdc_pkg::FPDC_IDLE,
      key: fpdc_pkg::REG_RST,
      dest: fpdc_pkg::REG_RST,
      default: '0
   };

   fpdc_top_state_type s_r, s_nxt;
   logic [fpdc_pkg::EV_W-1:0] ev;
   logic copy_ok;
   logic addr_ph;
   logic wr_req;

   fpdc_copy_if cp ();

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   // the request bit is never returned, only the busy flag beside it
   function automatic logic [31:0] read_reg(
      input logic [fpdc_pkg::OFS_W-1:0] ofs,
      input fpdc_top_state_type r
   );
      logic [31:0] v;
      v = '0;
      case (ofs)
         fpdc_pkg::OFS_CTRL: v[fpdc_pkg::BIT_BUSY] = r.req;
         fpdc_pkg::OFS_PSEL: v[fpdc_pkg::BIT_SEL] = r.psel;
         fpdc_pkg::OFS_ESEL: v[fpdc_pkg::BIT_SEL] = r.esel;
         fpdc_pkg::OFS_KEY: v = 32'(r.key);
         fpdc_pkg::OFS_DEST: v = 32'(r.dest);
         fpdc_pkg::OFS_EMU: v[fpdc_pkg::BIT_EMU] = r.emu;
         fpdc_pkg::OFS_ISTAT: v = 32'(r.istat);
         fpdc_pkg::OFS_IMASK: v = 32'(r.imask);
         default: v = '0;
      endcase
      return v;
   endfunction : read_reg

   // -------------------------------------------------------------
   // bus decode and gating terms
   // -------------------------------------------------------------
   assign addr_ph = hsel && hready && htrans[fpdc_pkg::HTRANS_ACT];
   assign wr_req = s_r.dph_wr && (s_r.dph_ofs == fpdc_pkg::OFS_CTRL)
                   && hwdata[fpdc_pkg::BIT_REQ];
   // all three conditions gate the request
   assign copy_ok = !s_r.emu && (s_r.key == fpdc_pkg::KEY_COPY)
                    && exec_in_ram;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   // bus write lands first; sequencer clears and event sets then
   // override it, so a hardware set is never lost to a w1c
   always_comb begin
      s_nxt = s_r;
      ev = '0;
      s_nxt.start = 1'b0;
      s_nxt.dph_wr = 1'b0;
      // address phase: capture target, read data ready for data phase
      if (addr_ph) begin
         s_nxt.dph_wr = hwrite;
         s_nxt.dph_ofs = haddr[fpdc_pkg::OFS_W-1:0];
         if (!hwrite) begin
            s_nxt.rdata = read_reg(haddr[fpdc_pkg::OFS_W-1:0], s_r);
         end
      end
      // data phase writes, byte lanes ignored: word access only
      if (s_r.dph_wr) begin
         case (s_r.dph_ofs)
            fpdc_pkg::OFS_CTRL: begin
               if (wr_req && copy_ok && s_r.st == fpdc_pkg::FPDC_IDLE) begin
                  if (s_r.dest > fpdc_pkg::DEST_MAX) begin
                     // out of range: flag and abandon
                     s_nxt.dest[fpdc_pkg::BIT_DERR] = 1'b1;
                     ev[fpdc_pkg::EV_DERR] = 1'b1;
                  end else if (!s_r.psel && !s_r.esel) begin
                     // nothing selected: finish with no copy
                     s_nxt.req = 1'b1;
                     s_nxt.st = fpdc_pkg::FPDC_DONE;
                  end else begin
                     // launch copy of the chosen routine
                     s_nxt.req = 1'b1;
                     s_nxt.start = 1'b1;
                     s_nxt.erase_sel = !s_r.psel;
                     s_nxt.st = fpdc_pkg::FPDC_COPY;
                  end
               end
            end
            // only bit zero of a select is stored
            fpdc_pkg::OFS_PSEL: s_nxt.psel = hwdata[fpdc_pkg::BIT_SEL];
            fpdc_pkg::OFS_ESEL: s_nxt.esel = hwdata[fpdc_pkg::BIT_SEL];
            fpdc_pkg::OFS_KEY: s_nxt.key = hwdata[7:0];
            fpdc_pkg::OFS_DEST: s_nxt.dest = hwdata[7:0];
            fpdc_pkg::OFS_EMU: s_nxt.emu = hwdata[fpdc_pkg::BIT_EMU];
            fpdc_pkg::OFS_ISTAT: begin
               s_nxt.istat = s_r.istat & ~hwdata[fpdc_pkg::EV_W-1:0];
            end
            fpdc_pkg::OFS_IMASK: begin
               s_nxt.imask = hwdata[fpdc_pkg::EV_W-1:0];
            end
            default: ;
         endcase
      end
      // sequencer
      unique case (s_r.st)
         fpdc_pkg::FPDC_IDLE: ;
         fpdc_pkg::FPDC_COPY: begin
            if (cp.done) begin
               s_nxt.st = fpdc_pkg::FPDC_DONE;
            end
         end
         fpdc_pkg::FPDC_DONE: begin
            s_nxt.req = 1'b0;
            s_nxt.psel = 1'b0;
            s_nxt.esel = 1'b0;
            ev[fpdc_pkg::EV_DONE] = 1'b1;
            s_nxt.st = fpdc_pkg::FPDC_IDLE;
         end
      endcase
      s_nxt.istat = s_nxt.istat | ev;
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // zero wait states, so hreadyout never stalls the master
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign irq = |(s_r.istat & s_r.imask);
   assign cp.start = s_r.start;
   assign cp.erase_sel = s_r.erase_sel;
   assign cp.dest = s_r.dest[fpdc_pkg::DEST_W-1:0];

   // copy engine
   fpdc_copier #(
      .WORDS(ROUTINE_WORDS),
      .DATA_W(DATA_W),
      .ROM_AW(ROM_AW),
      .RAM_AW(RAM_AW),
      .BLK_SH(BLK_SH)
   ) u_copier (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cp(cp),
      .rom_addr(rom_addr),
      .rom_data(rom_data),
      .ram_we(ram_we),
      .ram_addr(ram_addr),
      .ram_wdata(ram_wdata),
      .bank_switch(bank_switch)
   );

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_copy_launch: assert property (
      wr_req && copy_ok && s_r.st == fpdc_pkg::FPDC_IDLE
      && s_r.dest <= fpdc_pkg::DEST_MAX && (s_r.psel || s_r.esel)
      |=> s_r.start ##1 cp.busy)
      else $error("accepted request did not start the copy");

   a_key_gate: assert property (
      wr_req && !copy_ok && s_r.st == fpdc_pkg::FPDC_IDLE
      |=> s_r.st == fpdc_pkg::FPDC_IDLE && !s_r.req)
      else $error("request taken without emulation off, key and ram");

   a_req_bound: assert property (
      $rose(s_r.req) |-> ##[1:COPY_LIM] !s_r.req)
      else $error("request bit did not clear after download");

   a_req_done: assert property (
      cp.done |=> ##1 !s_r.req && s_r.istat[fpdc_pkg::EV_DONE])
      else $error("completion did not clear request and flag it");

   a_bank_hold: assert property (
      $rose(s_r.start) |=> bank_switch [*2])
      else $error("bank switch not active during copy");

   a_req_readzero: assert property (
      addr_ph && !hwrite && haddr[fpdc_pkg::OFS_W-1:0] == fpdc_pkg::OFS_CTRL
      |=> !hrdata[fpdc_pkg::BIT_REQ])
      else $error("request bit read back as one");

   a_psel_write: assert property (
      s_r.dph_wr && s_r.dph_ofs == fpdc_pkg::OFS_PSEL
      && s_r.st != fpdc_pkg::FPDC_DONE
      |=> s_r.psel == $past(hwdata[fpdc_pkg::BIT_SEL]))
      else $error("programming select not stored");

   a_psel_clear: assert property (
      s_r.st == fpdc_pkg::FPDC_DONE |=> !s_r.psel)
      else $error("programming select not cleared on completion");

   a_esel_write: assert property (
      s_r.dph_wr && s_r.dph_ofs == fpdc_pkg::OFS_ESEL
      && s_r.st != fpdc_pkg::FPDC_DONE
      |=> s_r.esel == $past(hwdata[fpdc_pkg::BIT_SEL]))
      else $error("erasing select not stored");

   a_esel_clear: assert property (
      s_r.st == fpdc_pkg::FPDC_DONE |=> !s_r.esel)
      else $error("erasing select not cleared on completion");

   a_sel_reserved: assert property (
      addr_ph && !hwrite
      && (haddr[fpdc_pkg::OFS_W-1:0] == fpdc_pkg::OFS_PSEL
      || haddr[fpdc_pkg::OFS_W-1:0] == fpdc_pkg::OFS_ESEL)
      |=> hrdata[31:1] == '0)
      else $error("reserved select bits read nonzero");

   a_dest_error: assert property (
      wr_req && copy_ok && s_r.st == fpdc_pkg::FPDC_IDLE
      && s_r.dest > fpdc_pkg::DEST_MAX
      |=> s_r.dest[fpdc_pkg::BIT_DERR] && !s_r.start
      && s_r.istat[fpdc_pkg::EV_DERR] ##1 !bank_switch)
      else $error("bad destination did not abandon the copy");

   c_prog_copy: cover property (cp.done && !s_r.erase_sel);
   c_erase_copy: cover property (cp.done && s_r.erase_sel);
   c_dest_err: cover property ($rose(s_r.dest[fpdc_pkg::BIT_DERR]));
   c_irq: cover property ($rose(irq));
endmodule : fpdc_top
`default_nettype wire

// ### inc/fpdc_pkg.sv
// constants and types shared by the routine download controller
package fpdc_pkg;
   // -------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // -------------------------------------------------------------
   localparam int OFS_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PSEL = 8'h04;
   localparam logic [7:0] OFS_ESEL = 8'h08;
   localparam logic [7:0] OFS_KEY = 8'h0C;
   localparam logic [7:0] OFS_DEST = 8'h10;
   localparam logic [7:0] OFS_EMU = 8'h14;
   localparam logic [7:0] OFS_ISTAT = 8'h18;
   localparam logic [7:0] OFS_IMASK = 8'h1C;
   // -------------------------------------------------------------
   // field positions and values
   // -------------------------------------------------------------
   localparam int BIT_REQ = 0;
   localparam int BIT_BUSY = 1;
   localparam int BIT_SEL = 0;
   localparam int BIT_EMU = 0;
   localparam int BIT_DERR = 7;
   localparam int DEST_W = 7;
   localparam int EV_W = 2;
   localparam int EV_DONE = 0;
   localparam int EV_DERR = 1;
   localparam int HTRANS_ACT = 1;
   localparam logic [7:0] KEY_COPY = 8'hA5;
   localparam logic [7:0] DEST_MAX = 8'h02;
   localparam logic [7:0] REG_RST = 8'h00;
   // -------------------------------------------------------------
   // sequencer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      FPDC_IDLE = 3'b001,
      FPDC_COPY = 3'b010,
      FPDC_DONE = 3'b100
   } fpdc_state_type;
endpackage : fpdc_pkg

// ### inc/fpdc_copy_if.sv
// handshake between the register side and the copy engine
`timescale 1ns/1ps
`default_nettype none
interface fpdc_copy_if;
   logic start;
   logic erase_sel;
   logic [fpdc_pkg::DEST_W-1:0] dest;
   logic busy;
   logic done;
   modport ctl (output start, output erase_sel, output dest,
                input busy, input done);
   modport eng (input start, input erase_sel, input dest,
                output busy, output done);
endinterface : fpdc_copy_if
`default_nettype wire

// ### hdl/fpdc_copier.sv
// copy engine: moves one routine from storage into on-chip ram
`timescale 1ns/1ps
`default_nettype none
module fpdc_copier #(
   parameter int WORDS = 16,
   parameter int DATA_W = 32,
   parameter int ROM_AW = 12,
   parameter int RAM_AW = 16,
   parameter int BLK_SH = 8,
   parameter logic [ROM_AW-1:0] PROG_BASE = '0,
   parameter logic [ROM_AW-1:0] ERASE_BASE = ROM_AW'(WORDS)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control from the register side
   fpdc_copy_if.eng cp,
   // routine storage read port, combinational read
   output logic [ROM_AW-1:0] rom_addr,
   input wire logic [DATA_W-1:0] rom_data,
   // on-chip ram write port
   output logic ram_we,
   output logic [RAM_AW-1:0] ram_addr,
   output logic [DATA_W-1:0] ram_wdata,
   // storage bank swap while copying
   output logic bank_switch
);
   localparam int CW = $clog2(WORDS + 1);
   localparam logic [CW-1:0] LAST = CW'(WORDS - 1);

   typedef struct packed {
      logic active;
      logic done;
      logic wr;
      logic [CW-1:0] cnt;
      logic [ROM_AW-1:0] raddr;
      logic [RAM_AW-1:0] dbase;
      logic [RAM_AW-1:0] waddr;
      logic [DATA_W-1:0] wdata;
   } fpdc_cp_state_type;

   fpdc_cp_state_type s_r, s_nxt;

   // -------------------------------------------------------------
   // word walk
   // -------------------------------------------------------------
   // destination latched at start so a later rewrite cannot tear it
   always_comb begin
      s_nxt = s_r;
      s_nxt.wr = 1'b0;
      s_nxt.done = 1'b0;
      if (cp.start && !s_r.active) begin
         s_nxt.active = 1'b1;
         s_nxt.cnt = '0;
         s_nxt.raddr = cp.erase_sel ? ERASE_BASE : PROG_BASE;
         s_nxt.dbase = RAM_AW'(cp.dest) << BLK_SH;
      end else if (s_r.active) begin
         s_nxt.wr = 1'b1;
         s_nxt.waddr = s_r.dbase + RAM_AW'(s_r.cnt);
         s_nxt.wdata = rom_data;
         s_nxt.cnt = s_r.cnt + CW'(1);
         s_nxt.raddr = s_r.raddr + ROM_AW'(1);
         if (s_r.cnt == LAST) begin
            s_nxt.active = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops, except bank swap, an OR of two flops
   assign rom_addr = s_r.raddr;
   assign ram_we = s_r.wr;
   assign ram_addr = s_r.waddr;
   assign ram_wdata = s_r.wdata;
   // bank swap held over the copy
   // the last word is written a cycle after the walk ends, keep it covered
   assign bank_switch = s_r.active || s_r.wr;
   assign cp.busy = s_r.active;
   assign cp.done = s_r.done;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_first_write: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      cp.start && !s_r.active |=> s_r.active ##1 ram_we)
      else $error("copy start did not lead to a ram write");
endmodule : fpdc_copier
`default_nettype wire

// ### test/fpdc_top_tb_top.sv
// self-checking bench for the routine download controller
`timescale 1ns/1ps
`default_nettype none
module fpdc_top_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int W = 4;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic exec_in_ram = 1'b0;
   logic hreadyout, hresp, ram_we, bank_switch, irq;
   logic [31:0] hrdata, ram_wdata, rom_data;
   logic [11:0] rom_addr;
   logic [15:0] ram_addr;
   logic [31:0] rom_mem [8];
   logic [31:0] rd_q [$];
   logic [47:0] wr_q [$];
   logic rd_dp = 1'b0;
   logic [7:0] dst;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 44168;

   // ----------------------------------------------------------------
   // clock, storage model and design
   // ----------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;
   // only eight storage words are modelled, enough for both routines
   assign rom_data = rom_mem[rom_addr[2:0]];

   fpdc_top #(.ROUTINE_WORDS(W)) fpdc_top_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .exec_in_ram(exec_in_ram), .rom_addr(rom_addr),
      .rom_data(rom_data), .ram_we(ram_we), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .bank_switch(bank_switch), .irq(irq)
   );

   // ----------------------------------------------------------------
   // comparison, verdict and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // one single transfer; called just after a rising edge
   task automatic ahb(input logic [7:0] a, input logic wr,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      if (!wr) rd_q.push_back(d);
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, e);
   endtask : rd

   // irq is a gate of registers: look once the edge has settled
   task automatic check_irq(input logic e);
      #1;
      check({47'h0, irq}, {47'h0, e}); // interrupt level
      // back onto an edge so the next transfer starts just after it
      @(posedge sys_clk);
   endtask : check_irq

   // full download of one routine into ram block d
   task automatic copy(input logic [7:0] d, input int base,
                       input logic [7:0] sel);
      for (int i = 0; i < W; i++)
         wr_q.push_back({d, 8'(i), rom_mem[base + i]});
      wr(sel, 32'h1);
      // destination and key set up before the request
      wr(fpdc_pkg::OFS_DEST, {24'h0, d});
      wr(fpdc_pkg::OFS_KEY, 32'hA5);
      wr(fpdc_pkg::OFS_CTRL, 32'h1);
      rd(fpdc_pkg::OFS_CTRL, 32'h2);
      rd(fpdc_pkg::OFS_CTRL, 32'h2);
      repeat (W + 4) @(posedge sys_clk);
      rd(fpdc_pkg::OFS_CTRL, 32'h0);
      rd(sel, 32'h0);
      rd(fpdc_pkg::OFS_ISTAT, 32'h1);
   endtask : copy

   // ----------------------------------------------------------------
   // result watcher: oldest note against what appears
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rd_dp && hreadyout === 1'b1)
         check({16'h0, hrdata}, {16'h0, rd_q.pop_front()});
      if (ram_we === 1'b1 && wr_q.size() == 0)
         check(48'h1, 48'h0); // no stray ram write
      else if (ram_we === 1'b1)
         check({ram_addr, ram_wdata}, wr_q.pop_front());
      if (ram_we === 1'b1)
         check({47'h0, bank_switch}, 48'h1);
      if (hreadyout === 1'b1)
         check({47'h0, hresp}, 48'h0); // refusal is silent
      if (hreadyout === 1'b1)
         rd_dp <= hsel && htrans[1] && !hwrite;
   end

   // hang guard: the whole run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge sys_clk);
      num_errors++;
      $display("timeout at t=%0t", $time);
      print_verdict();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      for (int i = 0; i < 8; i++)
         rom_mem[i] = $random(seed);
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      // reset values of every word and one unmapped word
      for (int a = 0; a <= 32; a += 4)
         rd(8'(a), 32'h0);
      wr(fpdc_pkg::OFS_PSEL, 32'hFF);
      rd(fpdc_pkg::OFS_PSEL, 32'h1);
      wr(fpdc_pkg::OFS_ESEL, 32'hFE);
      rd(fpdc_pkg::OFS_ESEL, 32'h0);
      // wrong key, emulation on, fetch outside ram
      for (int k = 0; k < 3; k++) begin
         exec_in_ram <= (k != 2);
         wr(fpdc_pkg::OFS_EMU, {31'h0, k == 1});
         wr(fpdc_pkg::OFS_KEY, k == 0 ? 32'h5A : 32'hA5);
         wr(fpdc_pkg::OFS_CTRL, 32'h1);
         rd(fpdc_pkg::OFS_CTRL, 32'h0);
         rd(fpdc_pkg::OFS_ISTAT, 32'h0);
      end
      exec_in_ram <= 1'b1;
      wr(fpdc_pkg::OFS_EMU, 32'h0);
      wr(fpdc_pkg::OFS_IMASK, 32'h1);
      // programming routine to a random legal block
      dst = 8'($unsigned($random(seed)) % 3);
      copy(dst, 0, fpdc_pkg::OFS_PSEL);
      check_irq(1'b1);
      wr(fpdc_pkg::OFS_ISTAT, 32'h1);
      rd(fpdc_pkg::OFS_ISTAT, 32'h0);
      check_irq(1'b0);
      // erasing routine to the top legal block, interrupt masked
      wr(fpdc_pkg::OFS_IMASK, 32'h0);
      copy(8'h02, W, fpdc_pkg::OFS_ESEL);
      check_irq(1'b0);
      wr(fpdc_pkg::OFS_IMASK, 32'h1);
      check_irq(1'b1);
      wr(fpdc_pkg::OFS_ISTAT, 32'h1);
      // first illegal destination abandons the copy
      wr(fpdc_pkg::OFS_PSEL, 32'h1);
      wr(fpdc_pkg::OFS_DEST, 32'h3);
      wr(fpdc_pkg::OFS_KEY, 32'hA5);
      wr(fpdc_pkg::OFS_CTRL, 32'h1);
      rd(fpdc_pkg::OFS_CTRL, 32'h0);
      rd(fpdc_pkg::OFS_DEST, 32'h83);
      rd(fpdc_pkg::OFS_ISTAT, 32'h2);
      // neither select set: completes with no ram write
      wr(fpdc_pkg::OFS_PSEL, 32'h0);
      wr(fpdc_pkg::OFS_DEST, 32'h0);
      wr(fpdc_pkg::OFS_ISTAT, 32'h3);
      wr(fpdc_pkg::OFS_CTRL, 32'h1);
      rd(fpdc_pkg::OFS_CTRL, 32'h2);
      rd(fpdc_pkg::OFS_ISTAT, 32'h1);
      wr(fpdc_pkg::OFS_ISTAT, 32'h1);
      // both selected: the programming routine is the one copied
      wr(fpdc_pkg::OFS_PSEL, 32'h1);
      copy(8'h01, 0, fpdc_pkg::OFS_ESEL);
      repeat (W + 4) @(posedge sys_clk);
      check(48'(wr_q.size()), 48'h0); // every word arrived
      print_verdict();
   end
endmodule : fpdc_top_tb_top
`default_nettype wire
